// ### logic/ausb_pkg.sv
// constants, register map and state types for the autobaud serial port
// assumes a single core clock and an avalon-mm register slave
package ausb_pkg;
  // register byte offsets, one aligned word each
  localparam logic [4:0] OFF_RX_STAT = 5'h00;
  localparam logic [4:0] OFF_RX_BUF = 5'h04;
  localparam logic [4:0] OFF_TX_BUF = 5'h08;
  localparam logic [4:0] OFF_TX_STAT = 5'h0C;
  localparam logic [4:0] OFF_BAUD_CTRL = 5'h10;
  localparam logic [4:0] OFF_DIV_LO = 5'h14;
  localparam logic [4:0] OFF_DIV_HI = 5'h18;
  localparam logic [4:0] OFF_FLAGS = 5'h1C;
  // receive_status_control fields
  localparam int B_PORT_EN = 7;
  localparam int B_RX9 = 6;
  localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
  // transmit_status_control fields
  localparam int B_TX9 = 6;
  localparam int B_TRANSMIT_ENABLE = 5;
  localparam int B_SYNC = 4;
  localparam int B_HIGH = 2;
  localparam int B_TRANSMIT_NINTH_BIT = 0;
  // baud_control fields
  localparam int B_OVF = 7;
  localparam int B_WIDE = 3;
  localparam int B_WAKE = 1;
  localparam int B_MEAS = 0;
  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_LO = 1'b0;
  localparam logic RST_HI = 1'b1;
  // cycle and tick counts
  localparam logic [3:0] SMP_LAST = 4'hF;
  localparam logic [3:0] SMP_HALF = 4'h7;
  localparam logic [3:0] RX_LAST8 = 4'h7;
  localparam logic [3:0] RX_LAST9 = 4'h8;
  localparam logic [3:0] TX_LAST8 = 4'h9;
  localparam logic [3:0] TX_LAST9 = 4'hA;
  localparam logic [2:0] MEAS_EDGE_LAST = 3'h4;
  localparam logic [1:0] X64_SUB_LAST = 2'h3;
  localparam logic [9:0] MEAS_PRE_CLR = 10'h1FF;
  localparam logic [9:0] MEAS_PRE_ONE = 10'h07F;
  localparam logic [9:0] MEAS_PRE_BOTH = 10'h01F;
  typedef enum logic [1:0] {MEAS_IDLE, MEAS_START, MEAS_RISE, MEAS_COUNT}
    ausb_meas_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ausb_rx_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} ausb_tx_t;
endpackage

// ### logic/ausb_baud_if.sv
// bundle between the port core and its baud generator
// assumes both ends share the core clock
`timescale 1ns/1ps
interface ausb_baud_if;
  logic [15:0] divisor;
  logic wide;
  logic high;
  logic measuring;
  logic sample_tick;
  logic meas_tick;
  modport core (output divisor, wide, high, measuring,
                input sample_tick, meas_tick);
  modport gen (input divisor, wide, high, measuring,
               output sample_tick, meas_tick);
endinterface

// ### logic/ausb_sync.sv
// three-stage synchroniser for the receive pin
// assumes the pin idles high
`timescale 1ns/1ps
module ausb_sync (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // pin and clean level
  input wire logic i_async,
  output logic o_level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  wire agree = (s2_reg == s3_reg);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= ausb_pkg::RST_HI;
      s2_reg <= ausb_pkg::RST_HI;
      s3_reg <= ausb_pkg::RST_HI;
      lvl_reg <= ausb_pkg::RST_HI;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= agree ? s3_reg : lvl_reg;
    end
  end
  assign o_level = lvl_reg;
endmodule // ausb_sync

// ### logic/ausb_baud.sv
// baud generator: sample ticks in normal use, counter clock when measuring
// assumes the divisor only changes between frames
`timescale 1ns/1ps
module ausb_baud (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // core side
  ausb_baud_if.gen bif
);
  logic [15:0] cnt_reg;
  logic [1:0] sub_reg;
  logic [9:0] pre_reg;
  logic smp_reg;
  logic meas_reg;
  // narrow mode ignores the high divisor byte
  wire [15:0] reload = bif.wide ? bif.divisor : {8'h00, bif.divisor[7:0]};
  wire raw_tick = (cnt_reg == 16'h0000);
  wire x64 = ~bif.wide & ~bif.high;
  wire both = bif.wide & bif.high;
  wire one = bif.wide ^ bif.high;
  wire [9:0] pre_last = both ? ausb_pkg::MEAS_PRE_BOTH :
    (one ? ausb_pkg::MEAS_PRE_ONE : ausb_pkg::MEAS_PRE_CLR);
  // >= so a select change mid-count cannot stall the prescaler
  wire pre_hit = (pre_reg >= pre_last);
  wire smp_next = raw_tick & ~bif.measuring &
    (~x64 | (sub_reg == ausb_pkg::X64_SUB_LAST));

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 16'h0000;
      sub_reg <= 2'h0;
      pre_reg <= 10'h000;
      smp_reg <= ausb_pkg::RST_LO;
      meas_reg <= ausb_pkg::RST_LO;
    end else begin
      cnt_reg <= (raw_tick | bif.measuring) ? reload : cnt_reg - 16'h0001;
      sub_reg <= raw_tick ? sub_reg + 2'h1 : sub_reg;
      pre_reg <= (~bif.measuring | pre_hit) ? 10'h000 : pre_reg + 10'h001;
      smp_reg <= smp_next;
      meas_reg <= bif.measuring & pre_hit;
    end
  end
  assign bif.sample_tick = smp_reg;
  assign bif.meas_tick = meas_reg;
endmodule // ausb_baud

// ### logic/ausb_top.sv
// serial port with automatic bit-rate measurement, avalon-mm slave
// assumes a master that holds each request until waitrequest is low
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
// How it works
// - measure only in async mode, wake clear
// - measure enable clears counter, awaits start bit
// - count from first rising receive edge
// - fifth rising edge: keep count, clear enable
// - counter wrap sets overflow, measurement continues
// - measure clock is one eighth normal rate; with wide and high both set it is one half (osc/32 against x16)
// - measure clock osc/512, /128 or /32
// - measurement always uses full 16-bit counter
// - receiver idle; ready flag at fifth edge
// - wake plus measure: measure after break
// - async frame: start, 8/9 data, stop
// - lsb first, shared framing and rate
// - generator tick at x16 or x64
// - no parity; ninth bit passes through
// - shifter reloads only after stop bit
// - transfer one cycle, then empty flag sets
// - empty flag clears second cycle after write
// - read-only shifter empty status bit
// - transmit enable sets empty flag; ninth bit
// - receiver samples at x16 baud
module ausb_top (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // avalon-mm register slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // serial lines
  input wire logic i_rx_line,
  output logic o_tx_line,
  // event flags
  output logic o_receive_ready,
  output logic o_transmit_empty
);
  // control and status
  logic port_en_reg, rx9_reg, continuous_receive_enable_reg, framing_error_reg, overrun_error_reg, rx_ninth_reg;
  logic tx9_reg, transmit_enable_reg, sync_reg, high_reg, tx_ninth_reg;
  logic ovf_reg, wide_reg, wake_reg, wake_seen_reg, meas_en_reg;
  logic [7:0] div_lo_reg, div_hi_reg, rx_buf_reg, tx_buf_reg;
  logic tx_full_reg, tx_flag_reg, rx_ready_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic rx_prev_reg;
  logic tx_line_reg;
  logic [2:0] edge_cnt_reg;
  logic [3:0] rx_smp_reg, rx_bit_reg, tx_smp_reg, tx_bit_reg;
  logic [8:0] rx_shift_reg;
  logic [10:0] tx_shift_reg;
  ausb_pkg::ausb_meas_t meas_state, meas_next;
  ausb_pkg::ausb_rx_t rx_state, rx_next;
  ausb_pkg::ausb_tx_t tx_state;
  logic rx_s;

  ausb_baud_if bif ();
  ausb_baud u_baud (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .bif(bif.gen)
  );
  ausb_sync u_rx_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_rx_line),
    .o_level(rx_s)
  );

  // bus decode: one wait cycle, access at the edge with waitrequest low
  wire req = i_avs_read | i_avs_write;
  wire acc = req & ~wait_reg;
  wire wr = acc & i_avs_write & i_avs_byteenable[0];
  wire rd = acc & i_avs_read;
  wire [7:0] wd = i_avs_writedata[7:0];
  wire [4:0] ad = i_avs_address;
  wire wr_rx_stat = wr & (ad == ausb_pkg::OFF_RX_STAT);
  wire wr_tx_buf = wr & (ad == ausb_pkg::OFF_TX_BUF);
  wire wr_tx_stat = wr & (ad == ausb_pkg::OFF_TX_STAT);
  wire wr_baud = wr & (ad == ausb_pkg::OFF_BAUD_CTRL);
  wire wr_div_lo = wr & (ad == ausb_pkg::OFF_DIV_LO);
  wire wr_div_hi = wr & (ad == ausb_pkg::OFF_DIV_HI);
  wire rd_rx_buf = rd & (ad == ausb_pkg::OFF_RX_BUF);

  wire shifter_empty = (tx_state == ausb_pkg::TX_IDLE);
  wire rx_idle = (rx_state == ausb_pkg::RX_IDLE);
  wire [7:0] rx_stat_val = {port_en_reg, rx9_reg, 1'b0, continuous_receive_enable_reg, 1'b0,
                            framing_error_reg, overrun_error_reg, rx_ninth_reg};
  wire [7:0] tx_stat_val = {1'b0, tx9_reg, transmit_enable_reg, sync_reg, 1'b0,
                            high_reg, shifter_empty, tx_ninth_reg};
  wire [7:0] baud_val = {ovf_reg, rx_idle, 2'b00, wide_reg, 1'b0,
                         wake_reg, meas_en_reg};
  wire [7:0] flags_val = {6'h00, rx_ready_reg, tx_flag_reg};
  // unmapped offsets read as zero
  wire [7:0] rmux =
    (ad == ausb_pkg::OFF_RX_STAT) ? rx_stat_val :
    (ad == ausb_pkg::OFF_RX_BUF) ? rx_buf_reg :
    (ad == ausb_pkg::OFF_TX_BUF) ? tx_buf_reg :
    (ad == ausb_pkg::OFF_TX_STAT) ? tx_stat_val :
    (ad == ausb_pkg::OFF_BAUD_CTRL) ? baud_val :
    (ad == ausb_pkg::OFF_DIV_LO) ? div_lo_reg :
    (ad == ausb_pkg::OFF_DIV_HI) ? div_hi_reg :
    (ad == ausb_pkg::OFF_FLAGS) ? flags_val : 8'h00;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_reg <= ausb_pkg::RST_HI;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= ~(req & wait_reg);
      rdata_reg <= (req & wait_reg) ? {24'h000000, rmux} : rdata_reg;
    end
  end

  // line edges
  wire rx_rise = rx_s & ~rx_prev_reg;
  wire rx_fall = ~rx_s & rx_prev_reg;

  // rate measurement
  wire [15:0] meas_cnt = {div_hi_reg, div_lo_reg};
  wire [15:0] meas_inc = meas_cnt + 16'h0001;
  wire meas_go = wr_baud & wd[ausb_pkg::B_MEAS] &
                 (meas_state == ausb_pkg::MEAS_IDLE);
  wire meas_allowed = ~sync_reg & ~wake_reg;
  wire meas_counting = (meas_state == ausb_pkg::MEAS_COUNT);
  wire meas_tick = meas_counting & bif.meas_tick;
  wire meas_done = meas_counting & rx_rise &
                   (edge_cnt_reg == ausb_pkg::MEAS_EDGE_LAST);
  wire meas_wrap = meas_tick & (meas_cnt == 16'hFFFF);
  // the first rise leaves MEAS_RISE, so it must be counted there too
  wire meas_edge = rx_rise &
                   (meas_counting | (meas_state == ausb_pkg::MEAS_RISE));

  always_comb begin
    meas_next = meas_state;
    unique case (meas_state)
      ausb_pkg::MEAS_IDLE: begin
        if (meas_go) begin
          meas_next = ausb_pkg::MEAS_START;
        end
      end
      ausb_pkg::MEAS_START: begin
        if (!meas_en_reg) begin
          meas_next = ausb_pkg::MEAS_IDLE;
        end else if (meas_allowed & rx_fall) begin
          meas_next = ausb_pkg::MEAS_RISE;
        end
      end
      ausb_pkg::MEAS_RISE: begin
        if (!meas_en_reg) begin
          meas_next = ausb_pkg::MEAS_IDLE;
        end else if (rx_rise) begin
          meas_next = ausb_pkg::MEAS_COUNT;
        end
      end
      ausb_pkg::MEAS_COUNT: begin
        if (!meas_en_reg | meas_done) begin
          meas_next = ausb_pkg::MEAS_IDLE;
        end
      end
    endcase
  end

  assign bif.divisor = meas_cnt;
  assign bif.wide = wide_reg;
  assign bif.high = high_reg;
  assign bif.measuring = meas_counting;

  // receiver
  wire rx_on = port_en_reg & continuous_receive_enable_reg & ~sync_reg & ~wake_reg &
               ~meas_en_reg & ~overrun_error_reg;
  wire tick = bif.sample_tick;
  wire [3:0] rx_last = rx9_reg ? ausb_pkg::RX_LAST9 : ausb_pkg::RX_LAST8;
  wire rx_mid = tick & (rx_smp_reg == ausb_pkg::SMP_LAST);
  wire rx_done = (rx_state == ausb_pkg::RX_STOP) & rx_mid;
  wire ovr_set = rx_done & rx_ready_reg;
  wire rx_store = rx_done & ~rx_ready_reg;
  wire [7:0] rx_byte = rx9_reg ? rx_shift_reg[7:0] : rx_shift_reg[8:1];

  always_comb begin
    rx_next = rx_state;
    unique case (rx_state)
      ausb_pkg::RX_IDLE: begin
        if (~rx_s) begin
          rx_next = ausb_pkg::RX_START;
        end
      end
      ausb_pkg::RX_START: begin
        if (tick & (rx_smp_reg == ausb_pkg::SMP_HALF)) begin
          rx_next = rx_s ? ausb_pkg::RX_IDLE : ausb_pkg::RX_DATA;
        end
      end
      ausb_pkg::RX_DATA: begin
        if (rx_mid & (rx_bit_reg == rx_last)) begin
          rx_next = ausb_pkg::RX_STOP;
        end
      end
      ausb_pkg::RX_STOP: begin
        if (rx_mid) begin
          rx_next = ausb_pkg::RX_IDLE;
        end
      end
    endcase
    if (!rx_on) begin
      rx_next = ausb_pkg::RX_IDLE;
    end
  end

  wire rx_rst_smp = (rx_state != rx_next) | (rx_mid & ~rx_idle);
  wire rx_shift_en = (rx_state == ausb_pkg::RX_DATA) & rx_mid;

  // transmitter
  wire tx_on = port_en_reg & transmit_enable_reg & ~sync_reg;
  wire tx_load = shifter_empty & tx_full_reg & tx_on;
  wire [3:0] tx_last = tx9_reg ? ausb_pkg::TX_LAST9 : ausb_pkg::TX_LAST8;
  wire tx_bit_end = tick & (tx_smp_reg == ausb_pkg::SMP_LAST);
  wire tx_stop_out = tx_bit_end & (tx_bit_reg == tx_last);
  // ninth bit is whatever software stored; no parity is made here
  wire tx_ninth = tx9_reg ? tx_ninth_reg : 1'b1;
  wire [10:0] tx_frame = {1'b1, tx_ninth, tx_buf_reg, 1'b0};

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meas_state <= ausb_pkg::MEAS_IDLE;
      rx_state <= ausb_pkg::RX_IDLE;
      tx_state <= ausb_pkg::TX_IDLE;
      rx_prev_reg <= ausb_pkg::RST_HI;
      edge_cnt_reg <= 3'h0;
      rx_smp_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      tx_smp_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= 11'h7FF;
      tx_line_reg <= ausb_pkg::RST_HI;
    end else begin
      meas_state <= meas_next;
      rx_state <= rx_next;
      rx_prev_reg <= rx_s;
      if (meas_next == ausb_pkg::MEAS_RISE) begin
        edge_cnt_reg <= 3'h0;
      end else if (meas_edge) begin
        edge_cnt_reg <= edge_cnt_reg + 3'h1;
      end
      rx_smp_reg <= rx_rst_smp ? 4'h0 : (tick ? rx_smp_reg + 4'h1 : rx_smp_reg);
      if (rx_state == ausb_pkg::RX_START) begin
        rx_bit_reg <= 4'h0;
      end else if (rx_shift_en) begin
        rx_bit_reg <= rx_bit_reg + 4'h1;
      end
      if (rx_shift_en) begin
        rx_shift_reg <= {rx_s, rx_shift_reg[8:1]};
      end
      if (!tx_on) begin
        tx_state <= ausb_pkg::TX_IDLE;
      end else if (tx_load) begin
        tx_state <= ausb_pkg::TX_SHIFT;
      end else if (tx_stop_out) begin
        tx_state <= ausb_pkg::TX_IDLE;
      end
      if (tx_load) begin
        tx_shift_reg <= tx_frame;
        tx_smp_reg <= 4'h0;
        tx_bit_reg <= 4'h0;
      end else if (tick) begin
        tx_smp_reg <= tx_smp_reg + 4'h1;
        if (tx_bit_end) begin
          tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
          tx_bit_reg <= tx_bit_reg + 4'h1;
        end
      end
      tx_line_reg <= shifter_empty | tx_shift_reg[0];
    end
  end

  // software-visible registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {port_en_reg, rx9_reg, continuous_receive_enable_reg} <= {3{ausb_pkg::RST_LO}};
      {tx9_reg, transmit_enable_reg, sync_reg, high_reg} <= {4{ausb_pkg::RST_LO}};
      {tx_ninth_reg, wide_reg, wake_reg} <= {3{ausb_pkg::RST_LO}};
      {wake_seen_reg, meas_en_reg, ovf_reg} <= {3{ausb_pkg::RST_LO}};
      {framing_error_reg, overrun_error_reg, rx_ninth_reg} <= {3{ausb_pkg::RST_LO}};
      {tx_full_reg, tx_flag_reg, rx_ready_reg} <= {3{ausb_pkg::RST_LO}};
      div_lo_reg <= ausb_pkg::RST_BYTE;
      div_hi_reg <= ausb_pkg::RST_BYTE;
      rx_buf_reg <= ausb_pkg::RST_BYTE;
      tx_buf_reg <= ausb_pkg::RST_BYTE;
    end else begin
      if (wr_rx_stat) begin
        port_en_reg <= wd[ausb_pkg::B_PORT_EN];
        rx9_reg <= wd[ausb_pkg::B_RX9];
        continuous_receive_enable_reg <= wd[ausb_pkg::B_CONTINUOUS_RECEIVE_ENABLE];
      end
      if (wr_tx_stat) begin
        tx9_reg <= wd[ausb_pkg::B_TX9];
        transmit_enable_reg <= wd[ausb_pkg::B_TRANSMIT_ENABLE];
        sync_reg <= wd[ausb_pkg::B_SYNC];
        high_reg <= wd[ausb_pkg::B_HIGH];
        tx_ninth_reg <= wd[ausb_pkg::B_TRANSMIT_NINTH_BIT];
      end
      if (wr_baud) begin
        wide_reg <= wd[ausb_pkg::B_WIDE];
      end
      // wake clears itself on the rising edge that ends the break
      if (wake_reg & wake_seen_reg & rx_rise) begin
        wake_reg <= ausb_pkg::RST_LO;
      end else if (wr_baud) begin
        wake_reg <= wd[ausb_pkg::B_WAKE];
      end
      wake_seen_reg <= wake_reg & (wake_seen_reg | rx_fall) & ~rx_rise;
      if (meas_done) begin
        meas_en_reg <= ausb_pkg::RST_LO;
      end else if (wr_baud) begin
        meas_en_reg <= wd[ausb_pkg::B_MEAS];
      end
      ovf_reg <= meas_wrap | (wr_baud ? wd[ausb_pkg::B_OVF] : ovf_reg);
      // measurement owns the divisor pair while it runs
      if (meas_go) begin
        {div_hi_reg, div_lo_reg} <= 16'h0000;
      end else if (meas_tick) begin
        {div_hi_reg, div_lo_reg} <= meas_inc;
      end else if (meas_state == ausb_pkg::MEAS_IDLE) begin
        div_lo_reg <= wr_div_lo ? wd : div_lo_reg;
        div_hi_reg <= wr_div_hi ? wd : div_hi_reg;
      end
      if (rx_store) begin
        rx_buf_reg <= rx_byte;
        rx_ninth_reg <= rx9_reg & rx_shift_reg[8];
        framing_error_reg <= ~rx_s;
      end
      overrun_error_reg <= (overrun_error_reg | ovr_set) & continuous_receive_enable_reg;
      rx_ready_reg <= rx_store | meas_done | (rx_ready_reg & ~rd_rx_buf);
      if (wr_tx_buf) begin
        tx_buf_reg <= wd;
      end
      tx_full_reg <= wr_tx_buf | (tx_full_reg & ~tx_load);
      tx_flag_reg <= transmit_enable_reg & ~tx_full_reg;
    end
  end

  assign o_avs_readdata = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_tx_line = tx_line_reg;
  assign o_receive_ready = rx_ready_reg;
  assign o_transmit_empty = tx_flag_reg;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  AST_MEAS_CLEAR: assert property (meas_go |=>
    (meas_cnt == 16'h0000 && meas_state == ausb_pkg::MEAS_START))
    else $error("measurement start did not clear counter");
  AST_MEAS_GATE: assert property (
    (meas_state == ausb_pkg::MEAS_START && (sync_reg || wake_reg))
    |=> meas_state != ausb_pkg::MEAS_RISE)
    else $error("measurement began while not allowed");
  AST_MEAS_DONE: assert property (meas_done |=>
    (!meas_en_reg && rx_ready_reg && meas_state == ausb_pkg::MEAS_IDLE))
    else $error("fifth edge did not end measurement");
  AST_MEAS_WRAP: assert property ((meas_wrap && !rx_rise) |=>
    (ovf_reg && meas_en_reg && meas_cnt == 16'h0000))
    else $error("counter wrap not trapped");
  AST_MEAS_HOLD: assert property ((meas_counting && !meas_tick &&
    !wr_baud) |=> $stable(meas_cnt))
    else $error("counter moved without its clock");
  AST_RX_QUIET: assert property (meas_en_reg |=> rx_idle)
    else $error("receiver ran during measurement");
  AST_RX_STORE: assert property (rx_store |=>
    (rx_ready_reg && framing_error_reg == !$past(rx_s)))
    else $error("completed character not stored");
  AST_RX_OVERRUN: assert property ((ovr_set && continuous_receive_enable_reg) |=> overrun_error_reg)
    else $error("overrun not flagged");
  AST_TX_FLAG_CLR: assert property ((wr_tx_buf && transmit_enable_reg) |=>
    ##1 !tx_flag_reg)
    else $error("empty flag not cleared after write");
  AST_TX_LOAD: assert property ((tx_load && !wr_tx_buf) |=>
    (!tx_full_reg && !shifter_empty) ##1 (tx_flag_reg || !transmit_enable_reg))
    else $error("transfer did not set empty flag");
  AST_TX_WAIT: assert property ((!shifter_empty && tx_full_reg && tx_on)
    |=> tx_full_reg)
    else $error("shifter reloaded before stop bit");
  AST_TX_START: assert property (tx_load |=> ##1 !o_tx_line)
    else $error("start bit missing");
  AST_BUS_ACK: assert property ((req && o_avs_waitrequest) |=>
    !o_avs_waitrequest)
    else $error("waitrequest held too long");

  COV_MEAS_DONE: cover property (meas_done);
  COV_MEAS_WRAP: cover property (meas_wrap);
  COV_RX_STORE: cover property (rx_store);
  COV_TX_BACK: cover property (tx_stop_out && tx_full_reg);
endmodule // ausb_top

// ### bench/ausb_remote.sv
// far-end serial node: drives the receive line with whole frames
// assumes the caller gives the bit time in core clocks
`timescale 1ns/1ps
module ausb_remote (
  // clock
  input wire logic i_core_clk,
  // serial line into the device
  output logic o_rx_line
);
  initial o_rx_line = 1'b1;
  // start low, data lsb first, stop high; idles high afterwards
  task automatic send(input logic [7:0] d, input int clks);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_core_clk);
      o_rx_line <= f[i];
      repeat (clks - 1) @(posedge i_core_clk);
    end
  endtask
endmodule // ausb_remote

// ### bench/tb.sv
// self-checking bench: avalon register tasks plus a remote serial node
// assumes the one-wait-state slave described for the register bus
`timescale 1ns/1ps
module tb;
  logic i_core_clk, i_rst_n, wr, rd, rx, o_tx_line, o_avs_waitrequest;
  logic o_receive_ready, o_transmit_empty;
  logic [4:0] adr;
  logic [31:0] wd, rdat, o_avs_readdata;
  int mismatches, num_checks, cyc;
  ausb_top i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_rx_line(rx), .o_tx_line(o_tx_line),
    .o_receive_ready(o_receive_ready), .o_transmit_empty(o_transmit_empty));
  ausb_remote i_remote (.i_core_clk(i_core_clk), .o_rx_line(rx));
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    adr <= a;
    wd <= {24'h000000, d};
    wr <= w;
    rd <= ~w;
    do @(posedge i_core_clk); while (o_avs_waitrequest !== 1'b0);
    rdat = o_avs_readdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wait_rdy();
    for (int k = 0; k < 4000 && o_receive_ready !== 1'b1; k++)
      @(posedge i_core_clk);
  endtask
  // samples mid-bit, 16 clocks per bit with the settings used here
  task automatic frame(input logic [7:0] d);
    logic [9:0] got;
    for (int k = 0; k < 2000 && o_tx_line !== 1'b0; k++)
      @(posedge i_core_clk);
    repeat (8) @(posedge i_core_clk);
    for (int i = 0; i < 10; i++) begin
      got[i] = o_tx_line;
      if (i < 9) repeat (16) @(posedge i_core_clk);
    end
    chk("tx_frame", {22'h0, got}, {22'h0, 1'b1, d, 1'b0});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    {wr, rd, adr, wd, i_rst_n, cyc} = '0;
    repeat (12) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    acc(1'b0, 5'h00, 8'h00);
    chk("rx_stat_rst", rdat, 32'h0);
    acc(1'b1, 5'h14, 8'h00);
    acc(1'b1, 5'h00, 8'h90);
    acc(1'b1, 5'h0C, 8'h24);
    repeat (3) @(posedge i_core_clk);
    chk("tx_empty_en", o_transmit_empty, 1);
    acc(1'b1, 5'h08, 8'hA5);
    repeat (2) @(posedge i_core_clk);
    chk("tx_empty_wr", o_transmit_empty, 0);
    @(posedge i_core_clk);
    chk("tx_empty_load", o_transmit_empty, 1);
    acc(1'b1, 5'h08, 8'h3C);
    acc(1'b0, 5'h0C, 8'h00);
    chk("shifter_busy", rdat, 32'h24);
    chk("tx_empty_full", o_transmit_empty, 0);
    frame(8'hA5);
    frame(8'h3C);
    $display("test transmit done");
    i_remote.send(8'h3C, 16);
    wait_rdy();
    i_remote.send(8'h5A, 16);
    repeat (40) @(posedge i_core_clk);
    acc(1'b0, 5'h00, 8'h00);
    chk("overrun", rdat, 32'h92);
    acc(1'b0, 5'h04, 8'h00);
    chk("rx_byte", rdat, 32'h3C);
    repeat (3) @(posedge i_core_clk);
    chk("rdy_clr", o_receive_ready, 0);
    acc(1'b1, 5'h00, 8'h80);
    acc(1'b0, 5'h00, 8'h00);
    chk("ovr_clr", rdat, 32'h80);
    $display("test receive done");
    // no transmit buffer write while measuring
    acc(1'b1, 5'h10, 8'h01);
    i_remote.send(8'h55, 256);
    wait_rdy();
    chk("meas_rdy", o_receive_ready, 1);
    acc(1'b0, 5'h14, 8'h00);
    chk("meas_lo", 32'(rdat inside {[15:17]}), 1);
    acc(1'b0, 5'h18, 8'h00);
    chk("meas_hi", rdat, 32'h0);
    acc(1'b0, 5'h10, 8'h00);
    chk("meas_en_clr", 32'(rdat[0]), 0);
    acc(1'b1, 5'h10, 8'h80);
    acc(1'b0, 5'h10, 8'h00);
    chk("ovf_set", rdat, 32'hC0);
    acc(1'b1, 5'h10, 8'h00);
    acc(1'b0, 5'h10, 8'h00);
    chk("ovf_clr", rdat, 32'h40);
    $display("test measure done");
    tally_and_finish();
  end
endmodule // tb
